// file: pkg/flash_fe_defs.svh
// Constants of the serial flash front end and its status bytes
// Summary of operation
// - Works with clock idling low or high
// - Sample on rising edge, drive after falling
// - Dual reads use two data lines
// - Quad reads use all four data lines
// - Quad reads need quad enable set
// - Select only after a chip select fall
// - Power-on reset ignores commands, restores defaults
// - Standby when deselected and not busy
// - Paused: outputs released, clock ignored, position kept
// - Deselect during pause aborts the transfer
// - Pause starts on hold low, clock low
// - Pause ends on hold high, clock low
// - Hold change with clock high waits
// - High byte bit 7 reads suspend state
// - Suspend sets flag, resume clears it
// - High bits 5..3 are one-time locks
// - Quad enable turns pins into data lines
// - High bit 0 is upper protect mode
// - Low bit 7 is lower protect mode
// - Mode 1 with write-protect low blocks writes, modes 2,3 always
// - Low bit 6 picks protect unit size
// - Low bit 5 picks protect direction
// - Low bits 4..2 protected size, zero none
// - Write latch must be set to start
// - Low bit 0 shows busy; all reset zero
`ifndef FLASH_FE_DEFS_SVH
`define FLASH_FE_DEFS_SVH

`define OFS_STATUS_LOW      5'h00
`define OFS_STATUS_HIGH     5'h04
`define OFS_FILL            5'h08
`define OFS_LINK            5'h0c

`define FILL_RESET          8'h00
`define LOW_CFG_RESET       6'h00
`define LOCK_RESET          3'h0
`define FLAG_RESET          1'b0

`define LOW_BIT_PROTECT_LO  7
`define LOW_CFG_LSB         2
`define HIGH_LOCK_LSB       3
`define HIGH_LOCK_MSB       5
`define HIGH_BIT_QUAD       1
`define HIGH_BIT_PROTECT_HI 0

`define OP_WRITE_STATUS     8'h01
`define OP_WRITE_DISABLE    8'h04
`define OP_READ_LOW         8'h05
`define OP_WRITE_ENABLE     8'h06
`define OP_READ_HIGH        8'h35
`define OP_DUAL_OUT         8'h3b
`define OP_QUAD_OUT         8'h6b
`define OP_SUSPEND          8'h75
`define OP_RESUME           8'h7a
`define OP_DUAL_IO          8'hbb
`define OP_QUAD_IO          8'heb

`define W_ONE               3'd1
`define W_TWO               3'd2
`define W_FOUR              3'd4

`define CLK_LAST_BIT        5'd7
`define CLK_ADDR_ONE        5'd24
`define CLK_ADDR_TWO        5'd16
`define CLK_ADDR_FOUR       5'd8
`define CLK_DUMMY_LONG      5'd8
`define CLK_DUMMY_QUAD      5'd4
`define CLK_DUMMY_NONE      5'd0

`define WRITE_TIME_NS       20000
`define CLK_PERIOD_NS       20

`endif

// file: pkg/flash_fe_pkg.sv
// Types of the serial flash front end
package flash_fe_pkg;
	typedef logic [31:0] word_t;
	typedef logic [4:0]  bus_addr_t;
	typedef logic [7:0]  byte_t;
	typedef logic [2:0]  width_t;
	typedef enum logic [2:0] {
		S_OFF, S_CMD, S_ADDR, S_DUMMY, S_WDATA, S_OUT, S_SKIP
	} link_state_e;
	typedef enum logic [1:0] {SRC_FILL, SRC_LOW, SRC_HIGH} out_src_e;
endpackage : flash_fe_pkg

// file: rtl/pin_filter.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_filter (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// Raw pin and filtered level
	input  wire logic pin,
	output logic      level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

	assign level = level_q;
endmodule : pin_filter

// file: rtl/flash_fe.sv
// Serial flash front end with status bytes and Avalon-MM access
`timescale 1ns/1ps
`include "flash_fe_defs.svh"
module flash_fe #(
	parameter int unsigned WRITE_CYCLES = `WRITE_TIME_NS / `CLK_PERIOD_NS
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	// Avalon-MM slave
	input  wire flash_fe_pkg::bus_addr_t avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire flash_fe_pkg::word_t     avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output flash_fe_pkg::word_t          avs_readdata,
	output logic                         avs_waitrequest,
	// Serial select and clock
	input  wire logic                    cs_n,
	input  wire logic                    sclk,
	// Data lines
	input  wire logic                    data_line_0_in,
	output logic                         data_line_0_out,
	output logic                         data_line_0_oe_n,
	input  wire logic                    data_line_1_in,
	output logic                         data_line_1_out,
	output logic                         data_line_1_oe_n,
	input  wire logic                    data_line_2_in,
	output logic                         data_line_2_out,
	output logic                         data_line_2_oe_n,
	input  wire logic                    data_line_3_in,
	output logic                         data_line_3_out,
	output logic                         data_line_3_oe_n,
	// Power state
	output logic                         standby
);
	import flash_fe_pkg::*;

	localparam logic [15:0] WRITE_LAST = 16'(WRITE_CYCLES - 1);

	// ------
	// Helpers
	// ------
	function automatic byte_t shift_in(byte_t r, width_t w,
		logic [3:0] d);
		case (w)
			`W_ONE:  shift_in = {r[6:0], d[0]};
			`W_TWO:  shift_in = {r[5:0], d[1:0]};
			default: shift_in = {r[3:0], d};
		endcase
	endfunction : shift_in

	function automatic logic [3:0] lines_out(byte_t b,
		logic [2:0] idx, width_t w);
		byte_t sh;
		sh = b << idx;
		case (w)
			`W_ONE:  lines_out = {2'b00, sh[7], 1'b0};
			`W_TWO:  lines_out = {2'b00, sh[7:6]};
			default: lines_out = sh[7:4];
		endcase
	endfunction : lines_out

	function automatic logic [3:0] oe_mask(width_t w);
		case (w)
			`W_ONE:  oe_mask = 4'hd;
			`W_TWO:  oe_mask = 4'hc;
			default: oe_mask = 4'h0;
		endcase
	endfunction : oe_mask

	// ------
	// Pin synchronisers
	// ------
	logic [5:0] pin_raw;
	logic [5:0] pin_f;
	assign pin_raw = {data_line_3_in, data_line_2_in, data_line_1_in,
		data_line_0_in, sclk, cs_n};
	for (genvar i = 0; i < 6; i++) begin : g_sync
		pin_filter u_sync (
			.clk   (clk),
			.rst_n (rst_n),
			.pin   (pin_raw[i]),
			.level (pin_f[i])
		);
	end

	// ------
	// State
	// ------
	link_state_e state_q, state_d;
	out_src_e    src_q, src_d;
	logic [4:0]  cnt_q, cnt_d;
	logic [4:0]  alen_q, alen_d;
	logic [4:0]  dlen_q, dlen_d;
	width_t      in_w_q, in_w_d;
	width_t      out_w_q, out_w_d;
	byte_t       rx_q, rx_d;
	byte_t       cmd_q, cmd_d;
	byte_t       lat_q, lat_d;
	byte_t       wb1_q, wb1_d;
	byte_t       wb2_q, wb2_d;
	logic [1:0]  wcnt_q, wcnt_d;
	logic [2:0]  idx_q, idx_d;
	logic [3:0]  dout_q, dout_d;
	logic [3:0]  oe_q, oe_d;
	logic        on_q, on_d;
	logic        cs_prev_q;
	logic        sclk_prev_q;
	logic        armed_q;
	logic        paused_q, paused_d;
	logic        standby_q;
	logic [5:0]  low_cfg_q;
	logic [2:0]  lock_q;
	logic        quad_enable_q;
	logic        protect_mode_hi_q;
	logic        write_latch_flag_q, write_latch_flag_d;
	logic        paused_op_flag_q, paused_op_flag_d;
	logic        busy_run_q;
	logic [15:0] bcnt_q;
	byte_t       fill_q;
	logic        wait_q;
	word_t       rdata_q;

	// ------
	// Decode
	// ------
	logic       cs_f, sclk_f, cs_rise, cs_fall, sel;
	logic       act_rise, act_fall, hold_n, wp_low;
	logic       busy_flag, busy_done, sr_locked, commit;
	logic       do_wrsr, do_wren, do_wrdi, do_sus, do_res;
	logic       is_rd_low, is_rd_high, is_wrsr, is_multi, is_quad;
	logic [3:0] din;
	byte_t      nxt_rx, src_byte, cur_byte, status_low, status_high;

	assign cs_f     = pin_f[0];
	assign sclk_f   = pin_f[1];
	assign din      = pin_f[5:2];
	assign hold_n   = din[3];
	assign wp_low   = ~quad_enable_q & ~din[2];
	assign cs_rise  = cs_f & ~cs_prev_q;
	assign cs_fall  = ~cs_f & cs_prev_q;
	assign sel      = state_q != S_OFF;
	// Edges of either clock polarity drive the same logic
	assign act_rise = sclk_f & ~sclk_prev_q & sel & ~paused_q;
	assign act_fall = ~sclk_f & sclk_prev_q & sel & ~paused_q;
	assign nxt_rx   = shift_in(rx_q, in_w_q, din);

	assign is_rd_low  = nxt_rx == `OP_READ_LOW;
	assign is_rd_high = nxt_rx == `OP_READ_HIGH;
	assign is_wrsr    = nxt_rx == `OP_WRITE_STATUS;
	assign is_quad    = nxt_rx == `OP_QUAD_OUT
		|| nxt_rx == `OP_QUAD_IO;
	assign is_multi   = is_quad || nxt_rx == `OP_DUAL_OUT
		|| nxt_rx == `OP_DUAL_IO;

	assign busy_flag   = busy_run_q & ~paused_op_flag_q;
	assign status_low  = {low_cfg_q, write_latch_flag_q, busy_flag};
	assign status_high = {paused_op_flag_q, 1'b0, lock_q, 1'b0,
		quad_enable_q, protect_mode_hi_q};
	assign src_byte = (src_q == SRC_LOW)  ? status_low :
		(src_q == SRC_HIGH) ? status_high : fill_q;
	assign cur_byte = (idx_q == 3'd0) ? src_byte : lat_q;

	// Upper mode bit locks outright, lower one through the pin
	assign sr_locked = protect_mode_hi_q
		| (low_cfg_q[`LOW_BIT_PROTECT_LO - `LOW_CFG_LSB]
		& wp_low);
	assign commit  = cs_rise & ~paused_q;
	assign do_wrsr = commit & (state_q == S_WDATA)
		& (wcnt_q != 2'd0) & write_latch_flag_q
		& ~busy_run_q & ~sr_locked;
	assign do_wren = commit & (state_q == S_SKIP)
		& (cmd_q == `OP_WRITE_ENABLE) & ~busy_run_q;
	assign do_wrdi = commit & (state_q == S_SKIP)
		& (cmd_q == `OP_WRITE_DISABLE) & ~busy_run_q;
	assign do_sus  = commit & (state_q == S_SKIP)
		& (cmd_q == `OP_SUSPEND) & busy_run_q;
	assign do_res  = commit & (state_q == S_SKIP)
		& (cmd_q == `OP_RESUME);
	assign busy_done = busy_flag & (bcnt_q == WRITE_LAST);

	assign write_latch_flag_d = do_wren ? 1'b1 :
		(do_wrdi | busy_done) ? 1'b0 : write_latch_flag_q;
	assign paused_op_flag_d = do_sus ? 1'b1 :
		do_res ? 1'b0 : paused_op_flag_q;

	// Hold acts only while the clock is low and quad is off
	assign paused_d = (~sel | cs_f) ? 1'b0 :
		(sclk_f | quad_enable_q) ? paused_q :
		~hold_n;
	assign oe_d = (state_q == S_OUT && on_q && !paused_q && !cs_f)
		? oe_mask(out_w_q) : 4'hf;

	// ------
	// Transfer sequencer
	// ------
	always_comb begin
		state_d = state_q;
		src_d   = src_q;
		cnt_d   = cnt_q;
		alen_d  = alen_q;
		dlen_d  = dlen_q;
		in_w_d  = in_w_q;
		out_w_d = out_w_q;
		rx_d    = rx_q;
		cmd_d   = cmd_q;
		lat_d   = lat_q;
		wb1_d   = wb1_q;
		wb2_d   = wb2_q;
		wcnt_d  = wcnt_q;
		idx_d   = idx_q;
		dout_d  = dout_q;
		on_d    = on_q;
		if (cs_f) begin
			state_d = S_OFF;
			on_d    = 1'b0;
		end else if (cs_fall && armed_q) begin
			state_d = S_CMD;
			cnt_d   = 5'd0;
			in_w_d  = `W_ONE;
			wcnt_d  = 2'd0;
		end else if (act_rise) begin
			rx_d  = nxt_rx;
			cnt_d = cnt_q + 5'd1;
			case (state_q)
				S_CMD: begin
					if (cnt_q == `CLK_LAST_BIT) begin
						cmd_d   = nxt_rx;
						cnt_d   = 5'd0;
						idx_d   = 3'd0;
						state_d = S_SKIP;
						if (is_rd_low || is_rd_high) begin
							state_d = S_OUT;
							out_w_d = `W_ONE;
							src_d   = is_rd_low ? SRC_LOW : SRC_HIGH;
						end else if (is_wrsr) begin
							state_d = S_WDATA;
						end else if (is_multi
							&& (quad_enable_q || !is_quad)) begin
							state_d = S_ADDR;
							src_d   = SRC_FILL;
							out_w_d = is_quad ? `W_FOUR : `W_TWO;
							in_w_d  = `W_ONE;
							alen_d  = `CLK_ADDR_ONE;
							dlen_d  = `CLK_DUMMY_LONG;
							if (nxt_rx == `OP_DUAL_IO) begin
								in_w_d = `W_TWO;
								alen_d = `CLK_ADDR_TWO;
								dlen_d = `CLK_DUMMY_NONE;
							end else if (nxt_rx == `OP_QUAD_IO) begin
								in_w_d = `W_FOUR;
								alen_d = `CLK_ADDR_FOUR;
								dlen_d = `CLK_DUMMY_QUAD;
							end
						end
					end
				end
				S_ADDR: begin
					if (cnt_q == alen_q - 5'd1) begin
						cnt_d   = 5'd0;
						state_d = (dlen_q == `CLK_DUMMY_NONE)
							? S_OUT : S_DUMMY;
					end
				end
				S_DUMMY: begin
					if (cnt_q == dlen_q - 5'd1) begin
						state_d = S_OUT;
					end
				end
				S_WDATA: begin
					if (cnt_q == `CLK_LAST_BIT) begin
						cnt_d = 5'd0;
						if (wcnt_q == 2'd0) begin
							wb1_d = nxt_rx;
						end else if (wcnt_q == 2'd1) begin
							wb2_d = nxt_rx;
						end
						if (wcnt_q != 2'd2) begin
							wcnt_d = wcnt_q + 2'd1;
						end
					end
				end
				default: begin
					cnt_d = cnt_q;
				end
			endcase
		end else if (act_fall && state_q == S_OUT) begin
			lat_d  = cur_byte;
			dout_d = lines_out(cur_byte, idx_q, out_w_q);
			idx_d  = idx_q + out_w_q;
			on_d   = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= S_OFF;
			src_q   <= SRC_FILL;
			cnt_q   <= 5'd0;
			alen_q  <= 5'd0;
			dlen_q  <= 5'd0;
			in_w_q  <= `W_ONE;
			out_w_q <= `W_ONE;
			rx_q    <= 8'h00;
			cmd_q   <= 8'h00;
			lat_q   <= 8'h00;
			wb1_q   <= 8'h00;
			wb2_q   <= 8'h00;
			wcnt_q  <= 2'd0;
			idx_q   <= 3'd0;
			dout_q  <= 4'h0;
			on_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			src_q   <= src_d;
			cnt_q   <= cnt_d;
			alen_q  <= alen_d;
			dlen_q  <= dlen_d;
			in_w_q  <= in_w_d;
			out_w_q <= out_w_d;
			rx_q    <= rx_d;
			cmd_q   <= cmd_d;
			lat_q   <= lat_d;
			wb1_q   <= wb1_d;
			wb2_q   <= wb2_d;
			wcnt_q  <= wcnt_d;
			idx_q   <= idx_d;
			dout_q  <= dout_d;
			on_q    <= on_d;
		end
	end

	// ------
	// Pin state, selection and pause
	// ------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_prev_q   <= 1'b0;
			sclk_prev_q <= 1'b0;
			armed_q     <= 1'b0;
			paused_q    <= 1'b0;
			oe_q        <= 4'hf;
			standby_q   <= 1'b0;
		end else begin
			cs_prev_q   <= cs_f;
			sclk_prev_q <= sclk_f;
			armed_q     <= armed_q | cs_f;
			paused_q    <= paused_d;
			oe_q        <= oe_d;
			standby_q   <= cs_f & ~busy_run_q;
		end
	end

	// ------
	// Status bytes and write cycle
	// ------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cfg_q          <= `LOW_CFG_RESET;
			lock_q             <= `LOCK_RESET;
			quad_enable_q      <= `FLAG_RESET;
			protect_mode_hi_q  <= `FLAG_RESET;
			write_latch_flag_q <= `FLAG_RESET;
			paused_op_flag_q   <= `FLAG_RESET;
			busy_run_q         <= `FLAG_RESET;
			bcnt_q             <= 16'h0000;
		end else begin
			if (do_wrsr) begin
				low_cfg_q <= wb1_q[7:`LOW_CFG_LSB];
				if (wcnt_q == 2'd2) begin
					lock_q <= lock_q
						| wb2_q[`HIGH_LOCK_MSB:`HIGH_LOCK_LSB];
					quad_enable_q     <= wb2_q[`HIGH_BIT_QUAD];
					protect_mode_hi_q <= wb2_q[`HIGH_BIT_PROTECT_HI];
				end
			end
			write_latch_flag_q <= write_latch_flag_d;
			paused_op_flag_q   <= paused_op_flag_d;
			if (do_wrsr) begin
				busy_run_q <= 1'b1;
				bcnt_q     <= 16'h0000;
			end else if (busy_done) begin
				busy_run_q <= 1'b0;
			end else if (busy_flag) begin
				bcnt_q <= bcnt_q + 16'h0001;
			end
		end
	end

	// ------
	// Avalon-MM slave
	// ------
	logic  bus_req, bus_take, fill_we;
	word_t rd_word;
	assign bus_req  = avs_read | avs_write;
	assign bus_take = bus_req & wait_q;
	assign fill_we  = avs_write & ~wait_q & avs_byteenable[0]
		& (avs_address == `OFS_FILL);
	assign rd_word =
		(avs_address == `OFS_STATUS_LOW)  ? {24'h0, status_low}  :
		(avs_address == `OFS_STATUS_HIGH) ? {24'h0, status_high} :
		(avs_address == `OFS_FILL)        ? {24'h0, fill_q}      :
		(avs_address == `OFS_LINK) ? {27'h0, busy_run_q, standby_q,
			paused_q, sel, armed_q} : 32'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
			fill_q  <= `FILL_RESET;
		end else begin
			wait_q <= ~bus_take;
			if (bus_take && avs_read) begin
				rdata_q <= rd_word;
			end
			if (fill_we) begin
				fill_q <= avs_writedata[7:0];
			end
		end
	end

	// ------
	// Outputs
	// ------
	assign avs_readdata     = rdata_q;
	assign avs_waitrequest  = wait_q;
	assign data_line_0_out  = dout_q[0];
	assign data_line_1_out  = dout_q[1];
	assign data_line_2_out  = dout_q[2];
	assign data_line_3_out  = dout_q[3];
	assign data_line_0_oe_n = oe_q[0];
	assign data_line_1_oe_n = oe_q[1];
	assign data_line_2_oe_n = oe_q[2];
	assign data_line_3_oe_n = oe_q[3];
	assign standby          = standby_q;

	// ------
	// Checks
	// ------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_bus_take;
		bus_req && wait_q;
	endsequence
	sequence s_bus_ack;
		!wait_q ##1 wait_q;
	endsequence
	sequence s_quad_refused;
		act_rise && state_q == S_CMD && cnt_q == `CLK_LAST_BIT
			&& is_quad && !quad_enable_q;
	endsequence

	chk_bus_answer: assert property (s_bus_take |=> s_bus_ack)
		else $error("bus answer not after one cycle");
	chk_select_edge: assert property (
		!armed_q |-> state_q == S_OFF)
		else $error("selected without prior chip select high");
	chk_select_start: assert property (
		armed_q && cs_fall && !cs_f |=> state_q == S_CMD)
		else $error("chip select fall did not start a command");
	chk_abort_state: assert property (
		cs_f |=> state_q == S_OFF && !paused_q)
		else $error("deselect did not clear the transfer");
	chk_pause_enter: assert property (
		sel && !cs_f && !quad_enable_q && !hold_n && !sclk_f
		|=> paused_q)
		else $error("pause not entered with clock low");
	chk_pause_leave: assert property (
		paused_q && !cs_f && hold_n && !sclk_f |=> !paused_q)
		else $error("pause not left with clock low");
	chk_pause_defer: assert property (
		sel && !cs_f && sclk_f |=> $stable(paused_q))
		else $error("pause changed while clock high");
	chk_pause_quiet: assert property (
		paused_q && !cs_f |=> &oe_q && $stable(state_q)
			&& $stable(cnt_q) && $stable(idx_q))
		else $error("paused transfer moved or drove lines");
	chk_quad_gate: assert property (s_quad_refused |=>
		state_q == S_SKIP)
		else $error("quad read taken without quad enable");
	chk_wel_gate: assert property (
		$rose(busy_run_q) |-> $past(write_latch_flag_q))
		else $error("write started without write latch");
	chk_locked_write: assert property (
		commit && sr_locked |=> $stable(low_cfg_q)
			&& $stable(quad_enable_q) && !$rose(busy_run_q))
		else $error("status changed while protected");
	chk_out_fall: assert property (
		$changed(dout_q) |-> $past(act_fall))
		else $error("output changed without falling clock");
	chk_suspend_set: assert property (
		do_sus |=> paused_op_flag_q && !busy_flag)
		else $error("suspend flag not set");
endmodule : flash_fe

// file: bench/host_model.sv
// Host serial master model for the flash front end pins
`timescale 1ns/1ps
module host_model (
	// Clock
	input  wire logic       clk,
	// Device side of the data lines
	input  wire logic [3:0] dev_out,
	input  wire logic [3:0] dev_oe_n,
	// Host pins
	output logic            cs_n,
	output logic            sclk,
	output logic [3:0]      line,
	// Frame result
	output logic            done,
	output logic [8:0]      got
);
	logic [3:0] host_oe;
	logic [3:0] host_val;
	logic [3:0] last_q;
	// Released lines: 0,1 toggle, 2,3 pulled up
	for (genvar k = 0; k < 4; k++) begin : g_res
		assign line[k] = !dev_oe_n[k] ? dev_out[k] :
			host_oe[k] ? host_val[k] : (k > 1) | ~last_q[k];
	end
	always @(posedge clk) last_q <= line;
	initial begin
		cs_n     = 1'b1;
		sclk     = 1'b0;
		host_oe  = 4'h0;
		host_val = 4'h0;
		done     = 1'b0;
		got      = 9'h000;
		last_q   = 4'h0;
	end
	task automatic half();
		repeat (4) @(posedge clk);
	endtask : half
	// Drive at fall, device samples at rise
	task automatic cyc(input logic [3:0] oe, input logic [3:0] v);
		sclk     <= 1'b0;
		host_oe  <= oe;
		host_val <= v;
		half();
		sclk <= 1'b1;
		half();
	endtask : cyc
	task automatic frame(input logic [7:0] op, input logic [15:0] wd,
		input int nw, input int ac, input int aw, input int dc,
		input int ow, input logic idle, input logic [31:0] rnd);
		logic [3:0] m;
		logic [7:0] b;
		logic       drv;
		b   = 8'h00;
		drv = 1'b0;
		m   = (aw == 4) ? 4'hf : (aw == 2) ? 4'h3 : 4'h1;
		@(posedge clk);
		sclk <= idle;
		half();
		cs_n <= 1'b0;
		half();
		for (int i = 7; i >= 0; i--) cyc(4'h1, {3'h0, op[i]});
		for (int i = nw - 1; i >= 0; i--) cyc(4'h1, {3'h0, wd[i]});
		for (int i = 0; i < ac; i++) cyc(m, rnd[(i % 8) * 4 +: 4]);
		for (int i = 0; i < dc; i++) cyc(4'h0, 4'h0);
		if (ow > 0) begin
			for (int i = 0; i < 8 / ow; i++) begin
				cyc(4'h0, 4'h0);
				drv = drv | ~&dev_oe_n;
				b   = (ow == 1) ? {b[6:0], line[1]} :
					(ow == 2) ? {b[5:0], line[1:0]} : {b[3:0], line};
			end
		end
		if (!idle) begin
			sclk <= 1'b0;
			half();
		end
		cs_n    <= 1'b1;
		host_oe <= 4'h0;
		half();
		half();
		if (ow > 0) begin
			got  <= {drv, b};
			done <= 1'b1;
			@(posedge clk);
			done <= 1'b0;
		end
	endtask : frame
endmodule : host_model

// file: bench/serial_flash_front_end_status_tb_top.sv
// Self-checking bench for the serial flash front end
`timescale 1ns/1ps
`include "flash_fe_defs.svh"
module serial_flash_front_end_status_tb_top;
	import flash_fe_pkg::*;
	localparam int unsigned WCYC = 200;
	localparam byte_t OPS[4] = '{`OP_DUAL_OUT, `OP_DUAL_IO,
		`OP_QUAD_OUT, `OP_QUAD_IO};
	localparam int ACS[4] = '{24, 16, 24, 8};
	localparam int AWS[4] = '{1, 2, 1, 4};
	localparam int DCS[4] = '{8, 0, 8, 4};
	localparam int OWS[4] = '{2, 2, 4, 4};
	logic        clk;
	logic        rst_n;
	bus_addr_t   avs_address;
	logic        avs_read;
	logic        avs_write;
	word_t       avs_writedata;
	logic [3:0]  avs_byteenable;
	word_t       avs_readdata;
	logic        avs_waitrequest;
	logic        cs_n;
	logic        sclk;
	logic [3:0]  line;
	logic [3:0]  dev_out;
	logic [3:0]  dev_oe_n;
	logic        standby;
	logic        done;
	logic [8:0]  got;
	word_t       exp_q[$];
	word_t       msk_q[$];
	int          fails;
	int          total_checks;
	logic [31:0] rnd;
	byte_t       fill;
	flash_fe #(.WRITE_CYCLES(WCYC)) flash_fe_i (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.cs_n(cs_n), .sclk(sclk),
		.data_line_0_in(line[0]), .data_line_0_out(dev_out[0]),
		.data_line_0_oe_n(dev_oe_n[0]),
		.data_line_1_in(line[1]), .data_line_1_out(dev_out[1]),
		.data_line_1_oe_n(dev_oe_n[1]),
		.data_line_2_in(line[2]), .data_line_2_out(dev_out[2]),
		.data_line_2_oe_n(dev_oe_n[2]),
		.data_line_3_in(line[3]), .data_line_3_out(dev_out[3]),
		.data_line_3_oe_n(dev_oe_n[3]), .standby(standby));
	host_model host_model_i (.clk(clk), .dev_out(dev_out),
		.dev_oe_n(dev_oe_n), .cs_n(cs_n), .sclk(sclk), .line(line),
		.done(done), .got(got));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input word_t seen, input word_t want);
		total_checks++;
		if (seen !== want) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic take(input word_t seen);
		if (exp_q.size() == 0)
			fails++;
		else
			check(seen & msk_q.pop_front(), exp_q.pop_front());
	endtask : take
	task automatic note(input word_t e, input word_t m);
		exp_q.push_back(e);
		msk_q.push_back(m);
	endtask : note
	task automatic bus(input logic wr, input bus_addr_t a, input word_t d);
		@(posedge clk);
		avs_read      <= !wr;
		avs_write     <= wr;
		avs_address   <= a;
		avs_writedata <= d;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd(input bus_addr_t a, input word_t e, input word_t m);
		note(e, m);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic spi(input byte_t op, input logic [15:0] wd,
		input int nw, input int ac, input int aw, input int dc,
		input int ow, input logic idle, input word_t e, input word_t m);
		if (ow > 0)
			note(e, m);
		rnd = lfsr(rnd);
		host_model_i.frame(op, wd, nw, ac, aw, dc, ow, idle, rnd);
	endtask : spi
	task automatic final_report();
		if (exp_q.size() != 0)
			fails++;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	// ----------------------------------------
	// Clock, monitor, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (avs_read && !avs_waitrequest)
			take(avs_readdata);
		if (done)
			take({23'h0, got});
	end
	initial begin
		repeat (40000) @(posedge clk);
		fails++;
		final_report();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		rst_n          = 1'b0;
		avs_address    = 5'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hf;
		fails          = 0;
		total_checks   = 0;
		rnd            = 32'hfb8a;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rd(`OFS_STATUS_LOW, 32'h0, '1);
		rd(`OFS_STATUS_HIGH, 32'h0, '1);
		rd(5'h10, 32'h0, '1);
		rd(`OFS_LINK, 32'h08, 32'h08);
		rnd  = lfsr(rnd);
		fill = rnd[7:0];
		bus(1'b1, `OFS_FILL, rnd);
		rd(`OFS_FILL, {24'h0, fill}, 32'hff);
		spi(`OP_READ_LOW, 0, 0, 0, 1, 0, 1, 1'b0, 32'h100, '1);
		spi(`OP_QUAD_IO, 0, 0, 8, 4, 4, 4, 1'b0, 32'h0, 32'h100);
		spi(`OP_WRITE_ENABLE, 0, 0, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		spi(`OP_READ_LOW, 0, 0, 0, 1, 0, 1, 1'b1, 32'h102, '1);
		spi(`OP_WRITE_STATUS, 16'h3c02, 16, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		rd(`OFS_STATUS_LOW, 32'h1, 32'h1);
		rd(`OFS_LINK, 32'h0, 32'h08);
		spi(`OP_SUSPEND, 0, 0, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		spi(`OP_READ_HIGH, 0, 0, 0, 1, 0, 1, 1'b0, 32'h182, '1);
		rd(`OFS_STATUS_LOW, 32'h3e, '1);
		spi(`OP_RESUME, 0, 0, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		rd(`OFS_STATUS_HIGH, 32'h02, '1);
		repeat (WCYC + 20) @(posedge clk);
		spi(`OP_WRITE_ENABLE, 0, 0, 0, 1, 0, 0, 1'b1, 32'h0, 32'h0);
		rd(`OFS_STATUS_LOW, 32'h3e, '1);
		spi(`OP_WRITE_DISABLE, 0, 0, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		rd(`OFS_STATUS_LOW, 32'h3c, '1);
		rd(`OFS_STATUS_HIGH, 32'h02, '1);
		for (int i = 0; i < 4; i++)
			spi(OPS[i], 0, 0, ACS[i], AWS[i], DCS[i], OWS[i], i[0],
				{23'h0, 1'b1, fill}, '1);
		spi(`OP_WRITE_ENABLE, 0, 0, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		spi(`OP_WRITE_STATUS, 16'h0001, 16, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		repeat (WCYC + 20) @(posedge clk);
		spi(`OP_WRITE_ENABLE, 0, 0, 0, 1, 0, 0, 1'b0, 32'h0, 32'h0);
		spi(`OP_WRITE_STATUS, 16'h3c02, 16, 0, 1, 0, 0, 1'b1, 32'h0, 32'h0);
		rd(`OFS_STATUS_HIGH, 32'h01, '1);
		rd(`OFS_STATUS_LOW, 32'h02, '1);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk);
		rd(`OFS_STATUS_HIGH, 32'h0, '1);
		spi(`OP_READ_LOW, 0, 0, 0, 1, 0, 1, 1'b0, 32'h100, '1);
		repeat (20) @(posedge clk);
		final_report();
	end
endmodule : serial_flash_front_end_status_tb_top
